/* File: hw/mrx_core_regs.vh */
// Constants for the mid-range instruction core: bus offsets, file map, opcodes, resets
`ifndef MRX_CORE_REGS_VH
`define MRX_CORE_REGS_VH
// Avalon register byte offsets
`define MRX_OFS_CTRL 5'h00
`define MRX_OFS_STATUS 5'h04
`define MRX_OFS_ACC 5'h08
`define MRX_OFS_PC 5'h0c
`define MRX_OFS_WDOG 5'h10
// Control fields and reset
`define MRX_CTRL_RUN_BIT 0
`define MRX_CTRL_WAKE_BIT 1
`define MRX_CTRL_RUN_RST 1'h1
// Status word field positions
`define MRX_ST_WRAP_BIT 0
`define MRX_ST_HALF_BIT 1
`define MRX_ST_NULL_BIT 2
`define MRX_ST_SLEEPF_BIT 3
`define MRX_ST_TIMEOUT_BIT 4
`define MRX_ST_ASLEEP_BIT 5
`define MRX_ST_IRQEN_BIT 6
// Special file addresses
`define MRX_F_TIMER 7'h01
`define MRX_F_FLAGS 7'h03
`define MRX_F_PORT 7'h06
`define MRX_F_UPPC 7'h0a
`define MRX_F_IRQCTL 7'h0b
`define MRX_IRQEN_POS 7
`define MRX_UPPC_LO 3
// Instruction classes and fixed words
`define MRX_CLS_BYTE 2'h0
`define MRX_CLS_BIT 2'h1
`define MRX_CLS_JUMP 2'h2
`define MRX_CLS_LIT 2'h3
`define MRX_W_RET 8'h08
`define MRX_W_IRQRET 8'h09
`define MRX_W_SLEEP 8'h63
`define MRX_W_KICK 8'h64
`define MRX_NOP_WORD 14'h0000
// Byte operation codes
`define MRX_OP_MISC 4'h0
`define MRX_OP_CLR 4'h1
`define MRX_OP_SUB 4'h2
`define MRX_OP_DEC 4'h3
`define MRX_OP_OR 4'h4
`define MRX_OP_AND 4'h5
`define MRX_OP_XOR 4'h6
`define MRX_OP_ADD 4'h7
`define MRX_OP_MOV 4'h8
`define MRX_OP_COM 4'h9
`define MRX_OP_INC 4'ha
`define MRX_OP_DECSZ 4'hb
`define MRX_OP_RR 4'hc
`define MRX_OP_RL 4'hd
`define MRX_OP_SWAP 4'he
`define MRX_OP_INCSZ 4'hf
// ALU selects
`define MRX_ALU_ADD 4'h0
`define MRX_ALU_SUB 4'h1
`define MRX_ALU_AND 4'h2
`define MRX_ALU_OR 4'h3
`define MRX_ALU_XOR 4'h4
`define MRX_ALU_COM 4'h5
`define MRX_ALU_INC 4'h6
`define MRX_ALU_DEC 4'h7
`define MRX_ALU_RL 4'h8
`define MRX_ALU_RR 4'h9
`define MRX_ALU_SWAP 4'ha
`define MRX_ALU_PASSB 4'hb
`define MRX_ALU_PASSA 4'hc
`define MRX_ALU_ZERO 4'hd
`endif

/* File: hw/mrx_alu.v */
// Eight-bit arithmetic and logic unit of the instruction core
`timescale 1ns/1ps
`include "mrx_core_regs.vh"
module mrx_alu (
  input wire [3:0] aluOp,
  input wire [7:0] accIn,
  input wire [7:0] operB,
  input wire wrapIn,
  output reg [7:0] result,
  output reg wrapOut,
  output reg halfOut,
  output wire isZero
);
  wire [8:0] sumFull;
  wire [4:0] sumHalf;
  wire [8:0] diffFull;
  wire [4:0] diffHalf;

  // Subtraction adds the inverted accumulator plus one, so carry high means no borrow
  assign sumFull = {1'b0, operB} + {1'b0, accIn};
  assign sumHalf = {1'b0, operB[3:0]} + {1'b0, accIn[3:0]};
  assign diffFull = {1'b0, operB} + {1'b0, ~accIn} + 9'h001;
  assign diffHalf = {1'b0, operB[3:0]} + {1'b0, ~accIn[3:0]} + 5'h01;
  assign isZero = (result == 8'h00);

  // Result mux; carry defaults to pass-through, half carry defaults to zero
  always @* begin
    result = operB;
    wrapOut = wrapIn;
    halfOut = 1'b0;
    case (aluOp)
      `MRX_ALU_ADD: begin
        result = sumFull[7:0];
        wrapOut = sumFull[8];
        halfOut = sumHalf[4];
      end
      `MRX_ALU_SUB: begin
        result = diffFull[7:0];
        wrapOut = diffFull[8];
        halfOut = diffHalf[4];
      end
      `MRX_ALU_AND: result = operB & accIn;
      `MRX_ALU_OR: result = operB | accIn;
      `MRX_ALU_XOR: result = operB ^ accIn;
      `MRX_ALU_COM: result = ~operB;
      `MRX_ALU_INC: result = operB + 8'h01;
      `MRX_ALU_DEC: result = operB - 8'h01;
      `MRX_ALU_RL: begin
        result = {operB[6:0], wrapIn};
        wrapOut = operB[7];
      end
      `MRX_ALU_RR: begin
        result = {wrapIn, operB[7:1]};
        wrapOut = operB[0];
      end
      `MRX_ALU_SWAP: result = {operB[3:0], operB[7:4]};
      `MRX_ALU_PASSB: result = operB;
      `MRX_ALU_PASSA: result = accIn;
      `MRX_ALU_ZERO: result = 8'h00;
      default: result = operB;
    endcase
  end
endmodule // mrx_alu

/* File: hw/mrx_core.v */
// Instruction execution core with file registers, return stack and Avalon status port
// Notes on behaviour
// - Clear accumulator loads zero and sets the null result flag.
// - Call pushes next address, loads 11-bit target, upper bits from latch.
// - Branch loads 11-bit target plus latch upper bits, two cycles, flags kept.
// - Watchdog kick clears count and prescaler, sets timeout and sleep flags.
// - File address 0..127; destination 0 is accumulator, 1 the file.
// - Invert file writes the complement and updates the null flag.
// - Decrement or increment file updates only the null flag.
// - Skip variants store result, skip next when zero, touch no flags.
// - OR and XOR literal into accumulator, null flag updated.
// - Load literal into accumulator; flags kept; spare bits ignored.
// - Store accumulator writes the file and keeps all flags.
// - Move file copies to destination and always updates null flag.
// - Interrupt return pops stack into counter and sets master enable.
// - Rotates go through the wrap bit and change only it.
// - Return literal loads accumulator, pops counter, two cycles, no flags.
// - Subroutine return pops counter, two cycles, no flag changes.
// - Sleep clears watchdog and prescaler, sets timeout, clears sleep flag, halts.
// - Literal minus accumulator updates wrap, half wrap and null flags.
// - File minus accumulator to destination, updates all three flags.
// - XOR and OR with file to destination, null flag updated.
// - Nibble swap exchanges halves, no flags changed.
// - Each instruction cycle is four clock periods.
// - Counter change or true skip adds a no-operation second cycle.
// - Read of the port register takes the pin levels.
// - Writing the timer register clears its prescaler when assigned to it.
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "mrx_core_regs.vh"
module mrx_core #(
  parameter STACK_DEPTH_LOG = 3,
  parameter WDOG_PRESCALE = 8'hff
) (
  input wire ref_clk,
  input wire rst,
  output wire [12:0] progAddr,
  input wire [13:0] progData,
  input wire [7:0] portPins,
  output wire [7:0] portLatch,
  input wire prescalerToTimer,
  output reg tmrPrescalerClr_reg,
  output reg asleep_reg,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest
);
  // One-hot oscillator phases inside an instruction cycle
  localparam [3:0] PH_Q1 = 4'b0001;
  localparam [3:0] PH_Q2 = 4'b0010;
  localparam [3:0] PH_Q3 = 4'b0100;
  localparam [3:0] PH_Q4 = 4'b1000;
  localparam STACK_DEPTH = 1 << STACK_DEPTH_LOG;

  reg [3:0] phase_reg;
  reg [12:0] pc_reg;
  reg [13:0] instr_reg;
  reg [7:0] acc_reg;
  reg [7:0] fileMem [0:127];
  reg [12:0] stackMem [0:STACK_DEPTH-1];
  reg [STACK_DEPTH_LOG-1:0] sp_reg;
  reg wrap_reg, half_reg, null_reg, timeout_reg, sleepFlag_reg;
  reg flush_reg, flushStep_reg, run_reg;
  // Set by a fetch, so a slot whose Q1 passed while halted never runs a stale word
  reg haveWord_reg;
  reg [7:0] wdogCount_reg;
  reg [7:0] wdogPre_reg;
  reg [7:0] pinMeta_reg, pinSync2_reg, pinSync3_reg, pinStable_reg;
  integer i;

  // Decoded controls
  reg [3:0] aluSel;
  reg useLit, wrAcc, wrFile, updNull, updWrap, updHalf, skipOnZero;
  reg doCall, doGoto, doRet, doRetIrq, doRetLit, doSleep, doKick;

  wire [1:0] cls;
  wire [3:0] op;
  wire [6:0] fAddr;
  wire [7:0] lit, fileVal, aluRes, upperLatch;
  wire dBit, aluWrap, aluHalf, aluZero, execNow, busFire, wakeReq;
  wire [12:0] popAddr, jumpAddr;

  assign progAddr = pc_reg;
  assign portLatch = fileMem[`MRX_F_PORT];
  assign cls = instr_reg[13:12];
  assign op = instr_reg[11:8];
  assign dBit = instr_reg[7];
  assign fAddr = instr_reg[6:0];
  assign lit = instr_reg[7:0];
  assign upperLatch = fileMem[`MRX_F_UPPC];
  assign jumpAddr = {upperLatch[`MRX_UPPC_LO+1:`MRX_UPPC_LO], instr_reg[10:0]};
  assign popAddr = stackMem[sp_reg - 1'b1];
  assign execNow = (phase_reg == PH_Q4) && run_reg && !asleep_reg && haveWord_reg;
  assign busFire = (avs_read || avs_write) && !avs_waitrequest;
  assign wakeReq = busFire && avs_write && (avs_address == `MRX_OFS_CTRL) &&
    avs_writedata[`MRX_CTRL_WAKE_BIT];

  // File read; special addresses map flags and the synchronised pins
  function [7:0] readFile;
    input [6:0] addr;
    begin
      if (addr == `MRX_F_FLAGS) begin
        readFile = {3'h0, timeout_reg, sleepFlag_reg, null_reg, half_reg, wrap_reg};
      end else if (addr == `MRX_F_PORT) begin
        readFile = pinStable_reg;
      end else begin
        readFile = fileMem[addr];
      end
    end
  endfunction

  assign fileVal = readFile(fAddr);

  mrx_alu uAlu (.aluOp(aluSel), .accIn(acc_reg), .operB(useLit ? lit : fileVal),
    .wrapIn(wrap_reg), .result(aluRes), .wrapOut(aluWrap), .halfOut(aluHalf),
    .isZero(aluZero));

  // Opcode map; bit-oriented class decodes as no-operation here
  always @* begin
    aluSel = `MRX_ALU_PASSB;
    {useLit, wrAcc, wrFile, updNull, updWrap, updHalf, skipOnZero} = 7'h00;
    {doCall, doGoto, doRet, doRetIrq, doRetLit, doSleep, doKick} = 7'h00;
    case (cls)
      `MRX_CLS_BYTE: begin
        wrAcc = !dBit;
        wrFile = dBit;
        case (op)
          `MRX_OP_MISC: begin
            wrAcc = 1'b0;
            aluSel = `MRX_ALU_PASSA;
            if (!dBit) begin
              wrFile = 1'b0;
              doRet = (lit == `MRX_W_RET);
              doRetIrq = (lit == `MRX_W_IRQRET);
              doSleep = (lit == `MRX_W_SLEEP);
              doKick = (lit == `MRX_W_KICK);
            end
          end
          `MRX_OP_CLR: begin
            aluSel = `MRX_ALU_ZERO;
            updNull = 1'b1;
          end
          `MRX_OP_SUB: begin
            aluSel = `MRX_ALU_SUB;
            {updNull, updWrap, updHalf} = 3'b111;
          end
          `MRX_OP_ADD: begin
            aluSel = `MRX_ALU_ADD;
            {updNull, updWrap, updHalf} = 3'b111;
          end
          `MRX_OP_DEC: {aluSel, updNull} = {`MRX_ALU_DEC, 1'b1};
          `MRX_OP_INC: {aluSel, updNull} = {`MRX_ALU_INC, 1'b1};
          `MRX_OP_OR: {aluSel, updNull} = {`MRX_ALU_OR, 1'b1};
          `MRX_OP_XOR: {aluSel, updNull} = {`MRX_ALU_XOR, 1'b1};
          `MRX_OP_AND: {aluSel, updNull} = {`MRX_ALU_AND, 1'b1};
          `MRX_OP_MOV: {aluSel, updNull} = {`MRX_ALU_PASSB, 1'b1};
          `MRX_OP_COM: {aluSel, updNull} = {`MRX_ALU_COM, 1'b1};
          `MRX_OP_DECSZ: {aluSel, skipOnZero} = {`MRX_ALU_DEC, 1'b1};
          `MRX_OP_INCSZ: {aluSel, skipOnZero} = {`MRX_ALU_INC, 1'b1};
          `MRX_OP_RR: {aluSel, updWrap} = {`MRX_ALU_RR, 1'b1};
          `MRX_OP_RL: {aluSel, updWrap} = {`MRX_ALU_RL, 1'b1};
          `MRX_OP_SWAP: aluSel = `MRX_ALU_SWAP;
          default: aluSel = `MRX_ALU_PASSB;
        endcase
      end
      `MRX_CLS_JUMP: begin
        doGoto = instr_reg[11];
        doCall = !instr_reg[11];
      end
      `MRX_CLS_LIT: begin
        useLit = 1'b1;
        wrAcc = 1'b1;
        case (op[3:2])
          2'b00: aluSel = `MRX_ALU_PASSB;
          2'b01: begin
            aluSel = `MRX_ALU_PASSB;
            doRetLit = 1'b1;
          end
          2'b10: begin
            updNull = (op[1:0] != 2'b11);
            wrAcc = (op[1:0] != 2'b11);
            case (op[1:0])
              2'b00: aluSel = `MRX_ALU_OR;
              2'b01: aluSel = `MRX_ALU_AND;
              2'b10: aluSel = `MRX_ALU_XOR;
              default: aluSel = `MRX_ALU_PASSB;
            endcase
          end
          default: begin
            aluSel = op[1] ? `MRX_ALU_ADD : `MRX_ALU_SUB;
            {updNull, updWrap, updHalf} = 3'b111;
          end
        endcase
      end
      default: aluSel = `MRX_ALU_PASSB;
    endcase
  end

  // Pin synchroniser: a change counts once the second and third stages agree
  always @(posedge ref_clk) begin
    if (rst) begin
      {pinMeta_reg, pinSync2_reg, pinSync3_reg, pinStable_reg} <= 32'h00000000;
    end else begin
      pinMeta_reg <= portPins;
      pinSync2_reg <= pinMeta_reg;
      pinSync3_reg <= pinSync2_reg;
      pinStable_reg <= (pinSync2_reg & pinSync3_reg) |
        (pinStable_reg & (pinSync2_reg ^ pinSync3_reg));
    end
  end

  // Phase counter runs free so the watchdog keeps its own pace while asleep
  always @(posedge ref_clk) begin
    if (rst) begin
      phase_reg <= PH_Q1;
    end else begin
      case (phase_reg)
        PH_Q1: phase_reg <= PH_Q2;
        PH_Q2: phase_reg <= PH_Q3;
        PH_Q3: phase_reg <= PH_Q4;
        PH_Q4: phase_reg <= PH_Q1;
        default: phase_reg <= PH_Q1;
      endcase
    end
  end

  // Fetch at Q1, execute at Q4; a pending flush turns the slot into a no-operation
  always @(posedge ref_clk) begin
    if (rst) begin
      pc_reg <= 13'h0000;
      instr_reg <= `MRX_NOP_WORD;
      acc_reg <= 8'h00;
      sp_reg <= {STACK_DEPTH_LOG{1'b0}};
      {wrap_reg, half_reg, null_reg} <= 3'b000;
      {timeout_reg, sleepFlag_reg} <= 2'h3;
      {flush_reg, flushStep_reg, haveWord_reg} <= 3'h0;
      {wdogCount_reg, wdogPre_reg} <= 16'h0000;
      asleep_reg <= 1'b0;
      tmrPrescalerClr_reg <= 1'b0;
      for (i = 0; i < 128; i = i + 1) begin
        fileMem[i] <= 8'h00;
      end
      for (i = 0; i < STACK_DEPTH; i = i + 1) begin
        stackMem[i] <= 13'h0000;
      end
    end else begin
      tmrPrescalerClr_reg <= 1'b0;
      if (wakeReq) begin
        asleep_reg <= 1'b0;
      end
      // Watchdog ticks once per instruction cycle through its prescaler
      if (phase_reg == PH_Q4) begin
        if (wdogPre_reg == WDOG_PRESCALE) begin
          wdogPre_reg <= 8'h00;
          wdogCount_reg <= wdogCount_reg + 8'h01;
        end else begin
          wdogPre_reg <= wdogPre_reg + 8'h01;
        end
      end
      if (phase_reg == PH_Q1 && run_reg && !asleep_reg) begin
        instr_reg <= flush_reg ? `MRX_NOP_WORD : progData;
        haveWord_reg <= 1'b1;
      end else if (phase_reg == PH_Q4) begin
        haveWord_reg <= 1'b0;
      end
      if (execNow && flush_reg) begin
        flush_reg <= 1'b0;
        if (flushStep_reg) begin
          pc_reg <= pc_reg + 13'h0001;
        end
      end else if (execNow) begin
        pc_reg <= pc_reg + 13'h0001;
        if (wrAcc) begin
          acc_reg <= aluRes;
        end
        if (wrFile) begin
          if (fAddr == `MRX_F_FLAGS) begin
            {half_reg, wrap_reg} <= aluRes[1:0];
            null_reg <= aluRes[2];
          end else begin
            fileMem[fAddr] <= aluRes;
          end
          if (fAddr == `MRX_F_TIMER && prescalerToTimer) begin
            tmrPrescalerClr_reg <= 1'b1;
          end
        end
        // Flag updates follow the file write so the operation's flags win
        if (updNull) begin
          null_reg <= aluZero;
        end
        if (updWrap) begin
          wrap_reg <= aluWrap;
        end
        if (updHalf) begin
          half_reg <= aluHalf;
        end
        if (skipOnZero && aluZero) begin
          flush_reg <= 1'b1;
          flushStep_reg <= 1'b1;
        end
        if (doCall) begin
          stackMem[sp_reg] <= pc_reg + 13'h0001;
          sp_reg <= sp_reg + 1'b1;
        end
        if (doCall || doGoto) begin
          pc_reg <= jumpAddr;
          flush_reg <= 1'b1;
          flushStep_reg <= 1'b0;
        end
        if (doRet || doRetIrq || doRetLit) begin
          pc_reg <= popAddr;
          sp_reg <= sp_reg - 1'b1;
          flush_reg <= 1'b1;
          flushStep_reg <= 1'b0;
        end
        if (doRetIrq) begin
          fileMem[`MRX_F_IRQCTL] <= fileMem[`MRX_F_IRQCTL] | 8'h80;
        end
        if (doKick || doSleep) begin
          wdogCount_reg <= 8'h00;
          wdogPre_reg <= 8'h00;
          timeout_reg <= 1'b1;
          sleepFlag_reg <= doKick;
        end
        if (doSleep) begin
          asleep_reg <= 1'b1;
        end
      end
    end
  end

  // Avalon slave: waitrequest drops one cycle after a request; writes land at the next edge, as it rises
  always @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      run_reg <= `MRX_CTRL_RUN_RST;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if ((avs_read || avs_write) && avs_waitrequest) begin
        case (avs_address)
          `MRX_OFS_CTRL: avs_readdata <= {31'h00000000, run_reg};
          `MRX_OFS_STATUS: avs_readdata <= {25'h0000000,
            fileMem[`MRX_F_IRQCTL][`MRX_IRQEN_POS], asleep_reg, timeout_reg,
            sleepFlag_reg, null_reg, half_reg, wrap_reg};
          `MRX_OFS_ACC: avs_readdata <= {24'h000000, acc_reg};
          `MRX_OFS_PC: avs_readdata <= {19'h00000, pc_reg};
          `MRX_OFS_WDOG: avs_readdata <= {16'h0000, wdogPre_reg, wdogCount_reg};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (busFire && avs_write && avs_address == `MRX_OFS_CTRL) begin
        run_reg <= avs_writedata[`MRX_CTRL_RUN_BIT];
      end
    end
  end
endmodule // mrx_core

/* File: test/mrx_core_monitor.sv */
// Concurrent checks on the instruction core ports
`timescale 1ns/1ps
`include "mrx_core_regs.vh"
module mrx_core_monitor #(
  parameter STACK_DEPTH_LOG = 3,
  parameter WDOG_PRESCALE = 8'hff
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [12:0] progAddr,
  input wire logic prescalerToTimer,
  input wire logic tmrPrescalerClr_reg,
  input wire logic asleep_reg,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A bus request meets exactly one wait cycle, then waitrequest is high again
  sequence req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_one_wait_a: assert property (req_seen |=> one_wait)
    else $error("bus answer not after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_idle_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");
  // Read data must stay put for the cycle after the answer, the master may sample late
  rdata_hold_a: assert property (!avs_waitrequest && avs_read |=> $stable(avs_readdata))
    else $error("read data moved after the answer");
  // An instruction cycle is four clocks, so the program address stands that long
  pc_stands_a: assert property ($changed(progAddr) |=> $stable(progAddr)[*3])
    else $error("program address changed inside an instruction cycle");
  asleep_freeze_a: assert property (asleep_reg && $past(asleep_reg) |-> $stable(progAddr))
    else $error("program address moved while halted");
  presc_pulse_a: assert property (tmrPrescalerClr_reg |=> !tmrPrescalerClr_reg)
    else $error("prescaler clear longer than one cycle");
  presc_cause_a: assert property ($rose(tmrPrescalerClr_reg) |-> $past(prescalerToTimer))
    else $error("prescaler cleared while not assigned to the timer");
  wake_cause_a: assert property ($fell(asleep_reg) |-> $past(avs_write)
    && $past(avs_address) == `MRX_OFS_CTRL && $past(avs_writedata[1]))
    else $error("left the halt without a wake write");
endmodule // mrx_core_monitor

bind mrx_core mrx_core_monitor #(
  .STACK_DEPTH_LOG(STACK_DEPTH_LOG),
  .WDOG_PRESCALE(WDOG_PRESCALE)
) mon_u (
  .ref_clk(ref_clk),
  .rst(rst),
  .progAddr(progAddr),
  .prescalerToTimer(prescalerToTimer),
  .tmrPrescalerClr_reg(tmrPrescalerClr_reg),
  .asleep_reg(asleep_reg),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest)
);

/* File: test/mrx_prog_mem.sv */
// Program memory model feeding instruction words to the core
`timescale 1ns/1ps
module mrx_prog_mem (
  input wire logic [12:0] progAddr,
  output wire logic [13:0] progData
);
  // Full 8K-word space; the bench fills it, so idle places hold a no-op
  logic [13:0] mem [0:8191];
  // Plain read: the core latches the word at its own fetch edge
  assign progData = mem[progAddr];
endmodule // mrx_prog_mem

/* File: test/midrange_core_instruction_exec_tb.sv */
// Self-checking bench for the instruction core
`timescale 1ns/1ps
`include "mrx_core_regs.vh"
module midrange_core_instruction_exec_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] progData;
  logic [12:0] progAddr;
  logic [7:0] portPins = 8'h3c;
  logic [7:0] portLatch;
  logic prescalerToTimer = 1'b0;
  logic tmrPrescalerClr_reg;
  logic asleep_reg;
  logic avs_waitrequest;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  int n_mismatch = 0;
  int compares = 0;
  int nPulse;
  // Rows: file value, acc value, operation word, expected acc, expected status
  logic [44:0] rows [0:19] = '{
    {8'h00, 8'h5a, 14'h0100, 8'h00, 7'h1c}, {8'ha5, 8'h00, 14'h0920, 8'h5a, 7'h18},
    {8'hff, 8'h00, 14'h0920, 8'h00, 7'h1c}, {8'h01, 8'h00, 14'h0320, 8'h00, 7'h1c},
    {8'hff, 8'h00, 14'h0a20, 8'h00, 7'h1c}, {8'h05, 8'h00, 14'h0b20, 8'h04, 7'h18},
    {8'h00, 8'h0f, 14'h38f0, 8'hff, 7'h18}, {8'h00, 8'h5a, 14'h3a5a, 8'h00, 7'h1c},
    {8'h00, 8'h5a, 14'h3300, 8'h00, 7'h18}, {8'h00, 8'h77, 14'h0820, 8'h00, 7'h1c},
    {8'h81, 8'h00, 14'h0d20, 8'h02, 7'h19}, {8'h01, 8'h00, 14'h0c20, 8'h00, 7'h19},
    {8'h00, 8'h01, 14'h3c03, 8'h02, 7'h1b}, {8'h00, 8'h02, 14'h3c01, 8'hff, 7'h18},
    {8'h05, 8'h05, 14'h0220, 8'h00, 7'h1f}, {8'h10, 8'h01, 14'h0220, 8'h0f, 7'h19},
    {8'hf0, 8'h0f, 14'h0620, 8'hff, 7'h18}, {8'h00, 8'h00, 14'h0420, 8'h00, 7'h1c},
    {8'ha5, 8'h00, 14'h0e20, 8'h5a, 7'h18}, {8'h10, 8'h00, 14'h0f20, 8'h11, 7'h18}};

  always #12.5 ref_clk = ~ref_clk;

  // Short watchdog prescale keeps any halt-time ticking inside the run
  mrx_core #(.STACK_DEPTH_LOG(3), .WDOG_PRESCALE(8'h03)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .progAddr(progAddr), .progData(progData),
    .portPins(portPins), .portLatch(portLatch), .prescalerToTimer(prescalerToTimer),
    .tmrPrescalerClr_reg(tmrPrescalerClr_reg), .asleep_reg(asleep_reg),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  mrx_prog_mem pm_u (.progAddr(progAddr), .progData(progData));

  // Counts prescaler clear pulses since the last reset
  always @(posedge ref_clk) begin
    if (rst) nPulse <= 0;
    else if (tmrPrescalerClr_reg === 1'b1) nPulse <= nPulse + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; holds everything until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // Only the bench watchdog ends a wait that never gets its answer
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic prog(input logic [13:0] w0, w1, w2, w3, w4);
    for (int a = 0; a < 8192; a++) pm_u.mem[a] = 14'h0000;
    pm_u.mem[0] = w0;
    pm_u.mem[1] = w1;
    pm_u.mem[2] = w2;
    pm_u.mem[3] = w3;
    pm_u.mem[4] = w4;
  endtask

  // Restart the core and let the short program settle into its final loop
  task automatic boot();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (60) @(posedge ref_clk);
  endtask

  task automatic expect_core(input logic [7:0] a, input logic [6:0] s);
    bus(1'b0, `MRX_OFS_ACC, 32'h0);
    chk(rd, {24'h0, a});
    bus(1'b0, `MRX_OFS_STATUS, 32'h0);
    chk(rd, {25'h0, s});
  endtask

  task automatic close_out();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    prog(14'h0, 14'h0, 14'h0, 14'h0, 14'h0);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values, unmapped place and read-only status
    bus(1'b0, `MRX_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, `MRX_OFS_STATUS, 32'hffffffff);
    bus(1'b1, 5'h14, 32'hffffffff);
    bus(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `MRX_OFS_STATUS, 32'h0);
    chk(rd, 32'h18);
    $display("test bus done");
    // Each row: load file 0x20, load acc, run the operation, loop in place
    foreach (rows[i]) begin
      prog({6'h30, rows[i][44:37]}, 14'h00a0, {6'h30, rows[i][36:29]}, rows[i][28:15],
           14'h2804);
      boot();
      expect_core(rows[i][14:7], rows[i][6:0]);
    end
    $display("test table done");
    // Call into the upper page, return with literal, branch keeps the latch bits
    prog(14'h3018, 14'h008a, 14'h2010, 14'h2803, 14'h0);
    pm_u.mem[13'h1810] = 14'h3442;
    pm_u.mem[13'h1803] = 14'h2803;
    boot();
    expect_core(8'h42, 7'h18);
    bus(1'b0, `MRX_OFS_PC, 32'h0);
    chk(rd, 32'h1803);
    $display("test call done");
    // Skip on zero: the word after the skip must not run
    for (int i = 0; i < 2; i++) begin
      prog(i ? 14'h30ff : 14'h3001, 14'h00a0, i ? 14'h0fa0 : 14'h0ba0, 14'h3099, 14'h2804);
      boot();
      expect_core(i ? 8'hff : 8'h01, 7'h18);
      bus(1'b0, `MRX_OFS_PC, 32'h0);
      chk(rd, 32'h4);
    end
    $display("test skip done");
    // Plain return and interrupt return
    for (int i = 0; i < 2; i++) begin
      prog(14'h2002, 14'h2801, i ? 14'h0009 : 14'h0008, 14'h0, 14'h0);
      boot();
      bus(1'b0, `MRX_OFS_STATUS, 32'h0);
      chk(rd, i ? 32'h58 : 32'h18);
      chk({19'h0, progAddr}, 32'h1);
    end
    $display("test return done");
    // Halt, wake by control write, then watchdog kick
    prog(14'h0063, 14'h0064, 14'h2802, 14'h0, 14'h0);
    boot();
    chk({31'h0, asleep_reg}, 32'h1);
    bus(1'b0, `MRX_OFS_STATUS, 32'h0);
    chk(rd, 32'h30);
    bus(1'b1, `MRX_OFS_CTRL, 32'h3);
    repeat (40) @(posedge ref_clk);
    bus(1'b0, `MRX_OFS_STATUS, 32'h0);
    chk(rd, 32'h18);
    $display("test sleep done");
    // Port rewrite takes pin levels; timer write clears the prescaler only if assigned
    for (int i = 0; i < 2; i++) begin
      prescalerToTimer <= i[0];
      // Leading no-op lets the pin levels pass the synchroniser before the rewrite
      prog(14'h0000, 14'h0886, 14'h0081, 14'h2803, 14'h0);
      boot();
      chk({24'h0, portLatch}, 32'h3c);
      chk(nPulse, i);
    end
    $display("test port done");
    close_out();
  end
endmodule // midrange_core_instruction_exec_tb
